// [hw/smbus_pointer_alert_slave.sv]
// management-bus slave front end: pointer access, out-of-range alert, query answer
// assumes a register file on the same clock that answers rd_data/rd_ok combinationally
`timescale 1ns/10ps
module smbus_pointer_alert_slave #(
  parameter int DATA_W = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic serial_line_data_in,
  output logic serial_line_data_out,
  output logic serial_line_data_oe,
  input wire logic [1:0] slave_id_strap0,
  input wire logic [1:0] slave_id_strap1,
  output logic [7:0] pointer,
  input wire logic [7:0] rd_data,
  input wire logic rd_ok,
  output logic reg_wr,
  output logic [7:0] wr_data,
  input wire logic signed [DATA_W-1:0] local_temp,
  input wire logic signed [DATA_W-1:0] remote_temp,
  input wire logic signed [DATA_W-1:0] local_high,
  input wire logic signed [DATA_W-1:0] local_low,
  input wire logic signed [DATA_W-1:0] remote_high,
  input wire logic signed [DATA_W-1:0] remote_low,
  input wire logic remote_open,
  output logic alert_out,
  output logic alert_oe,
  output logic [6:0] own_addr
);
  smbus_alert_pkg::slave_state_t cur;
  smbus_alert_pkg::slave_state_t next_cur;
  logic [5:0] pins;
  logic scl;
  logic sda;
  logic [1:0] strap0;
  logic [1:0] strap1;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic out_of_range;
  logic query_done;
  logic pointer_load;
  logic [7:0] rx_byte;

  pin_sync #(.WIDTH(6)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in({scl_in, serial_line_data_in, slave_id_strap0, slave_id_strap1}),
    .sync_out(pins)
  );
  assign {scl, sda, strap0, strap1} = pins;

  // an undriven code counts as open
  function automatic logic [1:0] strap_level(input logic [1:0] code);
    strap_level = (code == smbus_alert_pkg::STRAP_HIGH) ? 2'h2 :
                  (code == smbus_alert_pkg::STRAP_LOW) ? 2'h0 : 2'h1;
  endfunction : strap_level

  function automatic logic [6:0] strap_addr(input logic [1:0] s0, input logic [1:0] s1);
    logic [3:0] idx;
    idx = 4'(strap_level(s0) * smbus_alert_pkg::STRAP_LEVELS) + 4'(strap_level(s1));
    strap_addr = smbus_alert_pkg::SLAVE_ADDR_TABLE[idx];
  endfunction : strap_addr

  assign scl_rise = scl && !cur.scl_d;
  assign scl_fall = !scl && cur.scl_d;
  assign start_seen = scl && cur.scl_d && cur.sda_d && !sda;
  assign stop_seen = scl && cur.scl_d && !cur.sda_d && sda;
  assign rx_byte = cur.shift;

  assign out_of_range = (local_temp > local_high) || (local_temp < local_low) ||
                        (remote_temp > remote_high) || (remote_temp < remote_low);
  assign query_done = (cur.state == smbus_alert_pkg::ST_MASTER_ACK) && scl_rise && cur.is_query;
  assign pointer_load = (cur.state == smbus_alert_pkg::ST_RX) && scl_fall &&
                        (cur.bit_cnt == smbus_alert_pkg::BITS_PER_BYTE) &&
                        (cur.byte_idx == smbus_alert_pkg::BYTE_POINTER);

  always_comb begin
    next_cur = cur;
    next_cur.scl_d = scl;
    next_cur.sda_d = sda;
    next_cur.reg_wr = 1'b0;
    // capture after sync
    // synchroniser still shows its reset value for two edges
    if (!cur.addr_taken) begin
      if (cur.strap_wait == smbus_alert_pkg::STRAP_SETTLE) begin
        next_cur.own_addr = strap_addr(strap0, strap1);
        next_cur.addr_taken = 1'b1;
      end else begin
        next_cur.strap_wait = cur.strap_wait + 2'h1;
      end
    end
    // sink-only alert; new event beats the query release
    if (out_of_range || remote_open) begin
      next_cur.alert_oe = 1'b1;
    end else if (query_done) begin
      next_cur.alert_oe = 1'b0;
    end
    if (scl_rise && cur.state != smbus_alert_pkg::ST_TX) begin
      next_cur.shift = {cur.shift[6:0], sda};
    end
    case (cur.state)
      smbus_alert_pkg::ST_IDLE: begin
        next_cur.sda_oe = 1'b0;
      end
      smbus_alert_pkg::ST_ADDR: begin
        if (scl_rise) begin
          next_cur.bit_cnt = cur.bit_cnt + 4'h1;
        end
        if (scl_fall && cur.bit_cnt == smbus_alert_pkg::BITS_PER_BYTE) begin
          next_cur.is_read = rx_byte[0];
          next_cur.is_query = 1'b0;
          if (cur.addr_taken && rx_byte[7:1] == cur.own_addr &&
              cur.own_addr != smbus_alert_pkg::BUS_QUERY_RESPONSE_ADDR) begin
            next_cur.sda_oe = 1'b1;
            next_cur.state = smbus_alert_pkg::ST_ADDR_ACK;
          // query answered only with alert held
          end else if (rx_byte == {smbus_alert_pkg::BUS_QUERY_RESPONSE_ADDR, 1'b1} &&
                       cur.alert_oe) begin
            next_cur.is_query = 1'b1;
            next_cur.sda_oe = 1'b1;
            next_cur.state = smbus_alert_pkg::ST_ADDR_ACK;
          end else begin
            next_cur.state = smbus_alert_pkg::ST_IDLE;
          end
        end
      end
      smbus_alert_pkg::ST_ADDR_ACK: begin
        if (scl_fall) begin
          next_cur.bit_cnt = 4'h0;
          next_cur.byte_idx = smbus_alert_pkg::BYTE_POINTER;
          if (cur.is_read) begin
            if (cur.is_query) begin
              next_cur.tx = {cur.own_addr, 1'b0};
            end else if (rd_ok) begin
              next_cur.tx = rd_data;
            end else begin
              next_cur.tx = smbus_alert_pkg::UNREADABLE_BYTE;
            end
            next_cur.sda_oe = !next_cur.tx[7];
            next_cur.state = smbus_alert_pkg::ST_TX;
          end else begin
            next_cur.sda_oe = 1'b0;
            next_cur.state = smbus_alert_pkg::ST_RX;
          end
        end
      end
      smbus_alert_pkg::ST_RX: begin
        if (scl_rise) begin
          next_cur.bit_cnt = cur.bit_cnt + 4'h1;
        end
        if (scl_fall && cur.bit_cnt == smbus_alert_pkg::BITS_PER_BYTE) begin
          if (cur.byte_idx == smbus_alert_pkg::BYTE_POINTER) begin
            next_cur.pointer = rx_byte;
            next_cur.sda_oe = 1'b1;
            next_cur.state = smbus_alert_pkg::ST_RX_ACK;
          end else if (cur.byte_idx == smbus_alert_pkg::BYTE_DATA) begin
            next_cur.wr_data = rx_byte;
            next_cur.reg_wr = 1'b1;
            next_cur.sda_oe = 1'b1;
            next_cur.state = smbus_alert_pkg::ST_RX_ACK;
          end else begin
            next_cur.state = smbus_alert_pkg::ST_IDLE;
          end
        end
      end
      smbus_alert_pkg::ST_RX_ACK: begin
        if (scl_fall) begin
          next_cur.sda_oe = 1'b0;
          next_cur.bit_cnt = 4'h0;
          next_cur.byte_idx = cur.byte_idx + 2'h1;
          next_cur.state = smbus_alert_pkg::ST_RX;
        end
      end
      smbus_alert_pkg::ST_TX: begin
        if (scl_fall) begin
          next_cur.bit_cnt = cur.bit_cnt + 4'h1;
          next_cur.tx = {cur.tx[6:0], 1'b1};
          next_cur.sda_oe = !cur.tx[6];
          if (cur.bit_cnt == smbus_alert_pkg::BITS_PER_BYTE - 4'h1) begin
            next_cur.sda_oe = 1'b0;
            next_cur.state = smbus_alert_pkg::ST_MASTER_ACK;
          end
        end
      end
      smbus_alert_pkg::ST_MASTER_ACK: begin
        if (scl_rise) begin
          next_cur.state = smbus_alert_pkg::ST_IDLE;
        end
      end
      default: begin
        next_cur.state = smbus_alert_pkg::ST_IDLE;
        next_cur.sda_oe = 1'b0;
      end
    endcase
    if (start_seen) begin
      next_cur.state = smbus_alert_pkg::ST_ADDR;
      next_cur.bit_cnt = 4'h0;
      next_cur.sda_oe = 1'b0;
    end else if (stop_seen) begin
      next_cur.state = smbus_alert_pkg::ST_IDLE;
      next_cur.sda_oe = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '{state: smbus_alert_pkg::ST_IDLE, pointer: smbus_alert_pkg::POINTER_RESET,
               tx: smbus_alert_pkg::UNREADABLE_BYTE, scl_d: 1'b1, sda_d: 1'b1, default: '0};
    end else begin
      cur <= next_cur;
    end
  end

  // sink only, wire-and
  // open drain: data pins only ever carry low
  assign serial_line_data_out = 1'b0;
  assign alert_out = 1'b0;
  assign serial_line_data_oe = cur.sda_oe;
  assign alert_oe = cur.alert_oe;
  assign pointer = cur.pointer;
  assign reg_wr = cur.reg_wr;
  assign wr_data = cur.wr_data;
  assign own_addr = cur.own_addr;

  property p_limit_alert;
    @(posedge clock) disable iff (!rst_n) out_of_range |=> alert_oe;
  endproperty
  a_limit_alert: assert property (p_limit_alert) else $error("limit breach without alert");
  property p_open_alert;
    @(posedge clock) disable iff (!rst_n) remote_open |=> alert_oe;
  endproperty
  a_open_alert: assert property (p_open_alert) else $error("open sensor without alert");
  property p_alert_hold;
    @(posedge clock) disable iff (!rst_n) alert_oe && !query_done |=> alert_oe;
  endproperty
  a_alert_hold: assert property (p_alert_hold) else $error("alert dropped early");
  property p_pointer_load;
    @(posedge clock) disable iff (!rst_n) pointer_load |=> pointer == $past(rx_byte);
  endproperty
  a_pointer_load: assert property (p_pointer_load) else $error("pointer not loaded");
  sequence s_read_load;
    cur.state == smbus_alert_pkg::ST_ADDR_ACK && scl_fall && cur.is_read && !cur.is_query;
  endsequence
  property p_read_data;
    @(posedge clock) disable iff (!rst_n)
      s_read_load |=> cur.tx == ($past(rd_ok) ? $past(rd_data) : smbus_alert_pkg::UNREADABLE_BYTE);
  endproperty
  a_read_data: assert property (p_read_data) else $error("wrong read byte");
  property p_write_only;
    @(posedge clock) disable iff (!rst_n)
      s_read_load ##0 !rd_ok |=> cur.tx == smbus_alert_pkg::UNREADABLE_BYTE;
  endproperty
  a_write_only: assert property (p_write_only) else $error("write-only value leaked");
  property p_query_ack;
    @(posedge clock) disable iff (!rst_n)
      cur.is_query && cur.state == smbus_alert_pkg::ST_ADDR_ACK |-> $past(alert_oe);
  endproperty
  a_query_ack: assert property (p_query_ack) else $error("query acked without alert");
  property p_query_byte;
    @(posedge clock) disable iff (!rst_n)
      cur.state == smbus_alert_pkg::ST_ADDR_ACK && scl_fall && cur.is_query
      |=> cur.tx == {own_addr, 1'b0};
  endproperty
  a_query_byte: assert property (p_query_byte) else $error("query answer wrong");
  property p_strap_once;
    @(posedge clock) disable iff (!rst_n) cur.addr_taken |=> $stable(own_addr);
  endproperty
  a_strap_once: assert property (p_strap_once) else $error("address changed after capture");
  property p_single_write;
    @(posedge clock) disable iff (!rst_n) reg_wr |=> !reg_wr [*2];
  endproperty
  a_single_write: assert property (p_single_write) else $error("repeated write strobe");
endmodule : smbus_pointer_alert_slave

// [hw/smbus_alert_pkg.sv]
// constants and types of the pointer-based management-bus slave
// assumes a single 40 MHz clock and pads that resolve the bus pins to levels
package smbus_alert_pkg;
  localparam logic [6:0] BUS_QUERY_RESPONSE_ADDR = 7'h0C;
  localparam logic [7:0] UNREADABLE_BYTE = 8'hFF;
  localparam logic [7:0] POINTER_RESET = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] BYTE_POINTER = 2'h0;
  localparam logic [1:0] BYTE_DATA = 2'h1;
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_OPEN = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;
  localparam int STRAP_LEVELS = 3;
  // edges after reset before the synchronised straps are valid
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  localparam logic [6:0] SLAVE_ADDR_TABLE [0:8] = '{
    7'h18, 7'h19, 7'h1A, 7'h29, 7'h2A, 7'h2B, 7'h4C, 7'h4D, 7'h4E
  };

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_RX = 3'b011,
    ST_RX_ACK = 3'b100,
    ST_TX = 3'b101,
    ST_MASTER_ACK = 3'b110
  } bus_state_t;

  typedef struct packed {
    bus_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic [1:0] byte_idx;
    logic is_read;
    logic is_query;
    logic sda_oe;
    logic [7:0] pointer;
    logic reg_wr;
    logic [7:0] wr_data;
    logic alert_oe;
    logic [6:0] own_addr;
    logic addr_taken;
    logic [1:0] strap_wait;
    logic scl_d;
    logic sda_d;
  } slave_state_t;
endpackage : smbus_alert_pkg

// [hw/pin_sync.sv]
// two-stage synchroniser for asynchronous pin levels
// assumes the inputs are quasi-static compared with the clock
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : pin_sync

// [testbench/smbus_master_model.sv]
// bus master model: drives the bus clock and pulls the data line, open drain
// assumes the bench resolves the data wire with a pull-up from both enables
`timescale 1ns/10ps
module smbus_master_model (
  input wire logic clock,
  input wire logic sda_line,
  output logic scl,
  output logic sda_oe
);
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // changes land 2 ns after an edge, never on it
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : tick
  // half period of 8 clocks, twice the slave's minimum
  task automatic send_bit(input logic b);
    scl = 1'b0;
    tick(3);
    sda_oe = ~b;
    tick(5);
    scl = 1'b1;
    tick(8);
  endtask : send_bit
  task automatic get_bit(output logic b);
    scl = 1'b0;
    tick(3);
    sda_oe = 1'b0;
    tick(5);
    scl = 1'b1;
    tick(4);
    b = sda_line;
    tick(4);
  endtask : get_bit
  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      send_bit(v[i]);
    end
    get_bit(a);
    ack = ~a;
  endtask : put_byte
  task automatic frame_edge(input logic is_stop);
    scl = 1'b0;
    tick(3);
    sda_oe = is_stop;
    tick(5);
    scl = 1'b1;
    tick(8);
    sda_oe = ~is_stop;
    tick(8);
  endtask : frame_edge
  // pointer first, then up to two data bytes
  task automatic write_frame(input logic [6:0] a, input int n, input logic [7:0] b0,
                             input logic [7:0] b1, input logic [7:0] b2, output int acks);
    logic k;
    frame_edge(1'b0);
    put_byte({a, 1'b0}, k);
    acks = int'(k);
    for (int i = 0; i < n; i++) begin
      put_byte((i == 0) ? b0 : (i == 1) ? b1 : b2, k);
      acks += int'(k);
    end
    frame_edge(1'b1);
  endtask : write_frame
  // one byte read, then not-acknowledge and stop
  task automatic read_frame(input logic [6:0] a, output logic ack, output logic [7:0] v);
    frame_edge(1'b0);
    put_byte({a, 1'b1}, ack);
    for (int i = 7; i >= 0; i--) begin
      get_bit(v[i]);
    end
    send_bit(1'b1);
    frame_edge(1'b1);
  endtask : read_frame
endmodule : smbus_master_model

// [testbench/smbus_pointer_alert_slave_tb.sv]
// self-checking bench of the slave against the master model
// assumes a combinational register file here: pointers with bit 7 set are unreadable
`timescale 1ns/10ps
module smbus_pointer_alert_slave_tb;
  logic clock, rst_n, m_scl, m_oe, other_oe, op, ack, e;
  logic sda_oe, sda_out, alert_oe, alert_out, reg_wr;
  logic [1:0] strap0, strap1;
  logic [7:0] lt, rt, lh, ll, rh, rl, rnd, d, rbyte, pointer, wr_data, last_wr;
  logic [6:0] own_addr, me;
  int error_cnt = 0, checks_done = 0, cycles = 0, wr_cnt = 0, acks;
  wire sda_line = ~(sda_oe | m_oe);
  wire alert_line = ~(alert_oe | other_oe);
  wire rd_ok = ~pointer[7];
  wire [7:0] rd_data = pointer ^ 8'hA5;
  smbus_master_model host (.clock(clock), .sda_line(sda_line), .scl(m_scl), .sda_oe(m_oe));
  smbus_pointer_alert_slave uut (.clock(clock), .rst_n(rst_n), .scl_in(m_scl),
    .serial_line_data_in(sda_line), .serial_line_data_out(sda_out),
    .serial_line_data_oe(sda_oe), .slave_id_strap0(strap0), .slave_id_strap1(strap1),
    .pointer(pointer), .rd_data(rd_data), .rd_ok(rd_ok), .reg_wr(reg_wr),
    .wr_data(wr_data), .local_temp(lt), .remote_temp(rt), .local_high(lh),
    .local_low(ll), .remote_high(rh), .remote_low(rl), .remote_open(op),
    .alert_out(alert_out), .alert_oe(alert_oe), .own_addr(own_addr));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (reg_wr === 1'b1) begin
      wr_cnt++;
      last_wr = wr_data;
    end
    if (cycles == 40000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next
  // straps: 0 ground, 2 supply, anything else open
  function automatic logic [6:0] exp_addr(input logic [1:0] s0, input logic [1:0] s1);
    logic [6:0] base;
    base = (s0 == 2'h0) ? 7'h18 : (s0 == 2'h2) ? 7'h4C : 7'h29;
    return base + ((s1 == 2'h0) ? 7'h00 : (s1 == 2'h2) ? 7'h02 : 7'h01);
  endfunction : exp_addr
  function automatic logic exp_alert();
    return ($signed(lt) > $signed(lh)) || ($signed(lt) < $signed(ll)) ||
           ($signed(rt) > $signed(rh)) || ($signed(rt) < $signed(rl)) || op;
  endfunction : exp_alert
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // random in-range readings, limits never strictly passed
  task automatic safe();
    rnd = lfsr_next(rnd);
    lt = {2'h0, rnd[5:0]};
    rt = {2'h0, rnd[7:2]};
    lh = lt + {5'h00, rnd[2:0]};
    ll = lt - {5'h00, rnd[4:2]};
    rh = rt + {5'h00, rnd[5:3]};
    rl = rt - {5'h00, rnd[7:5]};
    op = 1'b0;
  endtask : safe
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    rst_n = 1'b0;
    strap0 = 2'h1;
    strap1 = 2'h1;
    other_oe = 1'b0;
    rnd = 8'h5B;
    safe();
    for (int i = 0; i < 16; i++) begin
      strap0 = i[3:2];
      strap1 = i[1:0];
      rst_n = 1'b0;
      host.tick(3);
      rst_n = 1'b1;
      host.tick(5);
      strap0 = ~strap0;
      host.tick(4);
      check("own_addr", {1'b0, own_addr}, {1'b0, exp_addr(i[3:2], i[1:0])});
    end
    check("drive levels", {6'h00, sda_out, alert_out}, 8'h00);
    $display("test straps done");
    // straps of the last pass: both codes 3, read as open
    me = exp_addr(2'h3, 2'h3);
    host.write_frame(me, 1, 8'h05, 8'h00, 8'h00, acks);
    check("pointer acks", acks[7:0], 8'h02);
    check("pointer", pointer, 8'h05);
    check("write count", wr_cnt[7:0], 8'h00);
    host.write_frame(me, 2, 8'h05, 8'h3C, 8'h00, acks);
    check("data acks", acks[7:0], 8'h03);
    check("write count", wr_cnt[7:0], 8'h01);
    check("write data", last_wr, 8'h3C);
    host.write_frame(me, 3, 8'h86, 8'h11, 8'h22, acks);
    check("third byte", acks[7:0], 8'h03);
    check("write data", last_wr, 8'h11);
    check("write count", wr_cnt[7:0], 8'h02);
    host.write_frame(me ^ 7'h01, 2, 8'h07, 8'h00, 8'h00, acks);
    check("foreign acks", acks[7:0], 8'h00);
    $display("test writes done");
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr_next(rnd);
      d = (i == 0) ? 8'h85 : rnd;
      host.write_frame(me, 1, d, 8'h00, 8'h00, acks);
      repeat (2) begin
        host.read_frame(me, ack, rbyte);
        check("read byte", rbyte, d[7] ? 8'hFF : d ^ 8'hA5);
      end
    end
    host.read_frame(7'h0C, ack, rbyte);
    check("idle query ack", {7'h00, ack}, 8'h00);
    $display("test reads done");
    for (int i = 0; i < 10; i++) begin
      rnd = lfsr_next(rnd);
      host.tick(1);
      lt = rnd;
      rt = rnd ^ 8'h5A;
      // first two passes sit exactly on every limit
      lh = (i < 2) ? lt : lt + 8'h02 - rnd[2:0];
      ll = (i < 2) ? lt : lt - 8'h02 + rnd[5:3];
      rh = (i < 2) ? rt : rt + 8'h01 - rnd[3:2];
      rl = (i < 2) ? rt : rt - 8'h01 + rnd[7:6];
      op = (i == 1);
      other_oe = rnd[1];
      e = exp_alert();
      host.tick(1);
      check("alert", {7'h00, alert_oe}, {7'h00, e});
      check("alert line", {7'h00, alert_line}, {7'h00, ~(e | other_oe)});
      if (e) begin
        safe();
        host.tick(3);
        check("alert held", {7'h00, alert_oe}, 8'h01);
        host.read_frame(7'h0C, ack, rbyte);
        check("query ack", {7'h00, ack}, 8'h01);
        check("query byte", rbyte, {me, 1'b0});
        check("alert freed", {7'h00, alert_oe}, 8'h00);
      end
    end
    $display("test alerts done");
    report_and_stop();
  end
endmodule : smbus_pointer_alert_slave_tb
